// file: prs_defines.svh
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH
// ==========================================
// register byte offsets
`define PRS_OFF_CAUSE 8'h00
`define PRS_OFF_RETURN_STACK_POINTER 8'h04
`define PRS_OFF_PCL 8'h08
`define PRS_OFF_LATH 8'h0c
`define PRS_OFF_LATU 8'h10
`define PRS_OFF_TOS 8'h14
`define PRS_OFF_PCRD 8'h18
// ==========================================
// cause register bit positions
`define PRS_B_INTERRUPT_PRIORITY_ENABLE 7
`define PRS_B_SOFTWARE_BROWNOUT_ENABLE 6
`define PRS_B_RI 4
`define PRS_B_TO 3
`define PRS_B_PD 2
`define PRS_B_POR 1
`define PRS_B_BOR 0
// ==========================================
// stack pointer register bit positions
`define PRS_B_FULL 7
`define PRS_B_UNF 6
// ==========================================
// vectors and constants
`define PRS_VEC_RESET 21'h000000
`define PRS_VEC_HIGH 21'h000008
`define PRS_VEC_LOW 21'h000018
`define PRS_PC_STEP 21'h000002
`define PRS_SP_MAX 5'h1f
`define PRS_SP_EMPTY 5'h00
`define PRS_BOR_SW 2'h1
`define PRS_RESP_OKAY 2'h0
`define PRS_RESP_SLVERR 2'h2
`endif

// file: prs_pkg.sv
package prs_pkg;
	typedef enum logic [3:0] {
		PRS_EV_NONE = 4'h0,
		PRS_EV_POR = 4'h1,
		PRS_EV_RESET_INSTR = 4'h2,
		PRS_EV_BROWNOUT = 4'h3,
		PRS_EV_EXTERNAL_MASTER_CLEAR_RUN = 4'h4,
		PRS_EV_EXTERNAL_MASTER_CLEAR_IDLE = 4'h5,
		PRS_EV_EXTERNAL_MASTER_CLEAR_FULL = 4'h6,
		PRS_EV_WDT_RUN = 4'h7,
		PRS_EV_WDT_SLEEP = 4'h8,
		PRS_EV_IRQ_WAKE = 4'h9
	} prs_event_e;
	typedef enum logic [3:0] {
		PRS_OP_NONE = 4'h0,
		PRS_OP_SEQ = 4'h1,
		PRS_OP_JUMP = 4'h2,
		PRS_OP_CALL = 4'h3,
		PRS_OP_RET = 4'h4,
		PRS_OP_IRQ_HIGH = 4'h5,
		PRS_OP_IRQ_LOW = 4'h6,
		PRS_OP_PCL_WR = 4'h7,
		PRS_OP_PCL_RD = 4'h8,
		PRS_OP_PUSH = 4'h9,
		PRS_OP_POP = 4'ha
	} prs_op_e;
	typedef enum logic [2:0] {
		PRS_RD_IDLE = 3'b001,
		PRS_RD_WAIT = 3'b010,
		PRS_RD_RESP = 3'b100
	} prs_rd_e;
endpackage

// file: prs_core.sv
`timescale 1ns/1ps
`include "prs_defines.svh"
module prs_core #(
	parameter int MEM_BYTES = 32768
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// configuration straps
	input wire logic [1:0] brownout_control_mode,
	input wire logic stack_overflow_reset_enable,
	// execution core
	input wire logic [3:0] core_op,
	input wire logic [20:0] core_target,
	input wire logic [7:0] core_pcl_wdata,
	input wire logic [3:0] reset_event,
	input wire logic global_irq_enable_high,
	input wire logic global_irq_enable_low,
	input wire logic [15:0] fetch_word,
	output logic [20:0] pc_out,
	output logic [15:0] fetch_data,
	output logic [7:0] pcl_rdata,
	output logic stack_reset_req,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ==========================================
	// state
	logic [20:0] pc_r;
	logic [7:0] pc_high_latch_r;
	logic [4:0] pc_upper_latch_r;
	logic [4:0] sp_r;
	logic [20:0] stack_mem [1:31];
	logic stack_full_flag_r;
	logic stack_underflow_flag_r;
	logic instruction_reset_flag_r;
	logic timeout_flag_r;
	logic power_down_flag_r;
	logic poweron_flag_r;
	logic brownout_flag_r;
	logic software_brownout_enable_r;
	logic interrupt_priority_enable_r;
	logic [20:0] tos_w;
	logic push_w;
	logic pop_w;
	logic sys_reset_w;
	logic full_trip_w;
	logic unf_trip_w;
	prs_pkg::prs_event_e ev;
	prs_pkg::prs_op_e op;
	// axi state
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic wr_go_w;
	logic [7:0] sw_wr_addr;
	logic sw_sp_wr_w;
	logic sw_tos_wr_w;
	logic [7:0] rd_addr_r;
	prs_pkg::prs_rd_e rd_st_r;

	assign ev = prs_pkg::prs_event_e'(reset_event);
	assign op = prs_pkg::prs_op_e'(core_op);

	// ==========================================
	// helpers
	function automatic logic [20:0] pc_align(input logic [20:0] a);
		pc_align = {a[20:1], 1'b0};
	endfunction

	function automatic logic [20:0] pc_next(input logic [20:0] a);
		pc_next = pc_align(a + `PRS_PC_STEP);
	endfunction

	// ==========================================
	// stack control
	assign push_w = (op == prs_pkg::PRS_OP_CALL) || (op == prs_pkg::PRS_OP_IRQ_HIGH) ||
		(op == prs_pkg::PRS_OP_IRQ_LOW) || (op == prs_pkg::PRS_OP_PUSH);
	assign pop_w = (op == prs_pkg::PRS_OP_RET) || (op == prs_pkg::PRS_OP_POP);
	assign tos_w = (sp_r == `PRS_SP_EMPTY) ? `PRS_VEC_RESET : stack_mem[sp_r];
	// 31st push with the overflow reset option on trips a reset
	assign full_trip_w = push_w && (sp_r == `PRS_SP_MAX - 5'h01) && stack_overflow_reset_enable;
	assign unf_trip_w = pop_w && (sp_r == `PRS_SP_EMPTY);
	assign sys_reset_w = (ev == prs_pkg::PRS_EV_POR) || (ev == prs_pkg::PRS_EV_RESET_INSTR) ||
		(ev == prs_pkg::PRS_EV_BROWNOUT) || (ev == prs_pkg::PRS_EV_EXTERNAL_MASTER_CLEAR_RUN) ||
		(ev == prs_pkg::PRS_EV_EXTERNAL_MASTER_CLEAR_IDLE) || (ev == prs_pkg::PRS_EV_EXTERNAL_MASTER_CLEAR_FULL) ||
		(ev == prs_pkg::PRS_EV_WDT_RUN);

	// ==========================================
	// stack array, no reset so it keeps contents across resets
	always_ff @(posedge aclk)
	begin
		if (sw_tos_wr_w && sp_r != `PRS_SP_EMPTY)
			stack_mem[sp_r] <= pc_align(w_data_r[20:0]);
		else if (!sys_reset_w && push_w && sp_r != `PRS_SP_MAX)
			stack_mem[sp_r + 5'h01] <= (op == prs_pkg::PRS_OP_PUSH) ? pc_r : pc_next(pc_r);
	end

	// ==========================================
	// stack pointer
	always_ff @(posedge aclk)
	begin
		if (!aresetn || sys_reset_w)
			sp_r <= `PRS_SP_EMPTY;
		else if (full_trip_w)
			sp_r <= `PRS_SP_EMPTY;
		else if (sw_sp_wr_w && w_strb_r[0])
			sp_r <= w_data_r[4:0];
		else if (push_w && sp_r != `PRS_SP_MAX)
			sp_r <= sp_r + 5'h01;
		else if (pop_w && sp_r != `PRS_SP_EMPTY)
			sp_r <= sp_r - 5'h01;
	end

	// ==========================================
	// stack flags, hardware set wins over software clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn || ev == prs_pkg::PRS_EV_POR)
		begin
			stack_full_flag_r <= 1'b0;
			stack_underflow_flag_r <= 1'b0;
		end
		else
		begin
			if (push_w && sp_r >= `PRS_SP_MAX - 5'h01)
				stack_full_flag_r <= 1'b1;
			else if (sw_sp_wr_w && w_strb_r[0] && !w_data_r[`PRS_B_FULL])
				stack_full_flag_r <= 1'b0;
			if (unf_trip_w)
				stack_underflow_flag_r <= 1'b1;
			else if (sw_sp_wr_w && w_strb_r[0] && !w_data_r[`PRS_B_UNF])
				stack_underflow_flag_r <= 1'b0;
		end
	end

	// ==========================================
	// reset-cause flags
	always_ff @(posedge aclk)
	begin
		if (!aresetn || ev == prs_pkg::PRS_EV_POR)
		begin
			instruction_reset_flag_r <= 1'b1;
			timeout_flag_r <= 1'b1;
			power_down_flag_r <= 1'b1;
			poweron_flag_r <= 1'b0;
			brownout_flag_r <= 1'b0;
			interrupt_priority_enable_r <= 1'b0;
			software_brownout_enable_r <= (brownout_control_mode == `PRS_BOR_SW);
		end
		else
		begin
			unique case (ev)
				prs_pkg::PRS_EV_RESET_INSTR: instruction_reset_flag_r <= 1'b0;
				prs_pkg::PRS_EV_BROWNOUT:
				begin
					instruction_reset_flag_r <= 1'b1;
					timeout_flag_r <= 1'b1;
					power_down_flag_r <= 1'b1;
					brownout_flag_r <= 1'b0;
				end
				prs_pkg::PRS_EV_EXTERNAL_MASTER_CLEAR_RUN: timeout_flag_r <= 1'b1;
				prs_pkg::PRS_EV_EXTERNAL_MASTER_CLEAR_IDLE:
				begin
					timeout_flag_r <= 1'b1;
					power_down_flag_r <= 1'b0;
				end
				prs_pkg::PRS_EV_WDT_RUN: timeout_flag_r <= 1'b0;
				prs_pkg::PRS_EV_WDT_SLEEP:
				begin
					timeout_flag_r <= 1'b0;
					power_down_flag_r <= 1'b0;
				end
				prs_pkg::PRS_EV_IRQ_WAKE: power_down_flag_r <= 1'b0;
				default:
				begin
					if (wr_go_w && sw_wr_addr == `PRS_OFF_CAUSE && w_strb_r[0])
					begin
						interrupt_priority_enable_r <= w_data_r[`PRS_B_INTERRUPT_PRIORITY_ENABLE];
						poweron_flag_r <= w_data_r[`PRS_B_POR];
						brownout_flag_r <= w_data_r[`PRS_B_BOR];
						if (brownout_control_mode == `PRS_BOR_SW)
							software_brownout_enable_r <= w_data_r[`PRS_B_SOFTWARE_BROWNOUT_ENABLE];
					end
				end
			endcase
			// other resets: software enable stays only in software mode
			if (sys_reset_w && ev != prs_pkg::PRS_EV_POR && brownout_control_mode != `PRS_BOR_SW)
				software_brownout_enable_r <= 1'b0;
		end
	end

	// ==========================================
	// program counter and latches
	always_ff @(posedge aclk)
	begin
		if (!aresetn || sys_reset_w || full_trip_w || unf_trip_w)
			pc_r <= `PRS_VEC_RESET;
		else if (ev == prs_pkg::PRS_EV_WDT_SLEEP)
			pc_r <= pc_next(pc_r);
		else if (ev == prs_pkg::PRS_EV_IRQ_WAKE)
		begin
			if (global_irq_enable_high)
				pc_r <= `PRS_VEC_HIGH;
			else if (global_irq_enable_low)
				pc_r <= `PRS_VEC_LOW;
			else
				pc_r <= pc_next(pc_r);
		end
		else
		begin
			unique case (op)
				prs_pkg::PRS_OP_SEQ: pc_r <= pc_next(pc_r);
				prs_pkg::PRS_OP_JUMP, prs_pkg::PRS_OP_CALL: pc_r <= pc_align(core_target);
				prs_pkg::PRS_OP_RET: pc_r <= tos_w;
				prs_pkg::PRS_OP_IRQ_HIGH: pc_r <= `PRS_VEC_HIGH;
				prs_pkg::PRS_OP_IRQ_LOW: pc_r <= `PRS_VEC_LOW;
				prs_pkg::PRS_OP_PCL_WR: pc_r <= {pc_upper_latch_r, pc_high_latch_r, core_pcl_wdata[7:1], 1'b0};
				prs_pkg::PRS_OP_PUSH, prs_pkg::PRS_OP_POP: pc_r <= pc_next(pc_r);
				default: pc_r <= pc_r;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || ev == prs_pkg::PRS_EV_POR)
		begin
			pc_high_latch_r <= 8'h00;
			pc_upper_latch_r <= 5'h00;
		end
		else if (op == prs_pkg::PRS_OP_PCL_RD)
		begin
			pc_high_latch_r <= pc_r[15:8];
			pc_upper_latch_r <= pc_r[20:16];
		end
		else if (wr_go_w && sw_wr_addr == `PRS_OFF_LATH && w_strb_r[0])
			pc_high_latch_r <= w_data_r[7:0];
		else if (wr_go_w && sw_wr_addr == `PRS_OFF_LATU && w_strb_r[0])
			pc_upper_latch_r <= w_data_r[4:0];
	end

	// ==========================================
	// core-facing outputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fetch_data <= 16'h0000;
			pcl_rdata <= 8'h00;
			stack_reset_req <= 1'b0;
		end
		else
		begin
			fetch_data <= (32'(pc_r) < 32'(MEM_BYTES)) ? fetch_word : 16'h0000;
			pcl_rdata <= pc_r[7:0];
			stack_reset_req <= full_trip_w || (unf_trip_w && stack_overflow_reset_enable);
		end
	end
	assign pc_out = pc_r;

	// ==========================================
	// axi write channel
	assign wr_go_w = aw_held_r && w_held_r && !s_axi_bvalid;
	assign sw_wr_addr = aw_addr_r;
	assign sw_sp_wr_w = wr_go_w && sw_wr_addr == `PRS_OFF_RETURN_STACK_POINTER;
	assign sw_tos_wr_w = wr_go_w && sw_wr_addr == `PRS_OFF_TOS;
	assign s_axi_awready = !aw_held_r && aresetn;
	assign s_axi_wready = !w_held_r && aresetn;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PRS_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go_w)
			begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (sw_wr_addr <= `PRS_OFF_PCRD && sw_wr_addr[1:0] == 2'h0) ?
					`PRS_RESP_OKAY : `PRS_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================
	// axi read channel
	assign s_axi_arready = (rd_st_r == prs_pkg::PRS_RD_IDLE) && aresetn;
	assign s_axi_rvalid = (rd_st_r == prs_pkg::PRS_RD_RESP);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rd_st_r <= prs_pkg::PRS_RD_IDLE;
			rd_addr_r <= 8'h00;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `PRS_RESP_OKAY;
		end
		else
		begin
			unique case (rd_st_r)
				prs_pkg::PRS_RD_IDLE:
					if (s_axi_arvalid)
					begin
						rd_addr_r <= s_axi_araddr;
						rd_st_r <= prs_pkg::PRS_RD_WAIT;
					end
				prs_pkg::PRS_RD_WAIT:
				begin
					s_axi_rresp <= `PRS_RESP_OKAY;
					unique case (rd_addr_r)
						`PRS_OFF_CAUSE: s_axi_rdata <= {24'h000000, interrupt_priority_enable_r,
							software_brownout_enable_r, 1'b0, instruction_reset_flag_r, timeout_flag_r,
							power_down_flag_r, poweron_flag_r, brownout_flag_r};
						`PRS_OFF_RETURN_STACK_POINTER: s_axi_rdata <= {24'h000000, stack_full_flag_r,
							stack_underflow_flag_r, 1'b0, sp_r};
						`PRS_OFF_PCL: s_axi_rdata <= {24'h000000, pc_r[7:0]};
						`PRS_OFF_LATH: s_axi_rdata <= {24'h000000, pc_high_latch_r};
						`PRS_OFF_LATU: s_axi_rdata <= {27'h0000000, pc_upper_latch_r};
						`PRS_OFF_TOS: s_axi_rdata <= {11'h000, tos_w};
						`PRS_OFF_PCRD: s_axi_rdata <= {11'h000, pc_r};
						default:
						begin
							s_axi_rdata <= 32'h00000000;
							s_axi_rresp <= `PRS_RESP_SLVERR;
						end
					endcase
					rd_st_r <= prs_pkg::PRS_RD_RESP;
				end
				prs_pkg::PRS_RD_RESP:
					if (s_axi_rready)
						rd_st_r <= prs_pkg::PRS_RD_IDLE;
			endcase
		end
	end
endmodule

// file: prs_fetch_mem.sv
`timescale 1ns/1ps
// ==========
// program memory model
module prs_fetch_mem (
	// address in
	input wire logic [20:0] pc_out,
	// instruction word out
	output logic [15:0] fetch_word
);
	assign fetch_word = pc_out[16:1] ^ 16'h5a5a;
endmodule

// file: prs_core_assertions.sv
`timescale 1ns/1ps
module prs_core_checker #(
	parameter int MEM_BYTES = 32768
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// execution core
	input wire logic [3:0] core_op,
	input wire logic [20:0] core_target,
	input wire logic [3:0] reset_event,
	input wire logic global_irq_enable_high,
	input wire logic [20:0] pc_out,
	input wire logic [15:0] fetch_data,
	// read channel
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	// ==========
	// properties
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic quiet = reset_event == prs_pkg::PRS_EV_NONE;
	seq_step_a: assert property (quiet && core_op == prs_pkg::PRS_OP_SEQ |=> pc_out == $past(pc_out) + 21'h2)
		else $error("sequential step wrong");
	pc_align_a: assert property (pc_out[0] == 1'b0)
		else $error("pc bit 0 set");
	jump_load_a: assert property (quiet && core_op == prs_pkg::PRS_OP_JUMP |=> pc_out == $past(core_target))
		else $error("jump target not loaded");
	irq_high_a: assert property (quiet && core_op == prs_pkg::PRS_OP_IRQ_HIGH |=> pc_out == 21'h8)
		else $error("high vector wrong");
	irq_low_a: assert property (quiet && core_op == prs_pkg::PRS_OP_IRQ_LOW |=> pc_out == 21'h18)
		else $error("low vector wrong");
	por_vec_a: assert property (reset_event == prs_pkg::PRS_EV_POR |=> pc_out == 21'h0)
		else $error("power-on pc not zero");
	wdt_sleep_a: assert property (reset_event == prs_pkg::PRS_EV_WDT_SLEEP |=> pc_out == $past(pc_out) + 21'h2)
		else $error("sleep timeout pc wrong");
	wake_vec_a: assert property (reset_event == prs_pkg::PRS_EV_IRQ_WAKE && global_irq_enable_high |=> pc_out == 21'h8)
		else $error("wake vector wrong");
	fetch_zero_a: assert property (pc_out >= MEM_BYTES |=> fetch_data == 16'h0)
		else $error("fetch beyond memory not zero");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
		else $error("read answer late");
	rst_pc_a: assert property ($rose(aresetn) |-> pc_out == 21'h0)
		else $error("pc not zero after reset");
endmodule
bind prs_core prs_core_checker #(.MEM_BYTES(MEM_BYTES)) u_prs_core_checker (.aclk, .aresetn, .core_op, .core_target,
	.reset_event, .global_irq_enable_high, .pc_out, .fetch_data, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// file: pc_return_stack_reset_status_tb.sv
`timescale 1ns/1ps
`include "prs_defines.svh"
module pc_return_stack_reset_status_tb;
	// ==========
	// signals
	logic aclk = 1'b0, aresetn = 1'b0, ovr = 1'b0, gh = 1'b0, gl = 1'b0, srq;
	logic [1:0] mode = 2'h1, bresp, rresp, r;
	logic [3:0] op = 4'h0, ev = 4'h0;
	logic [20:0] tgt = 21'h0, pc;
	logic [7:0] pclw = 8'h0, awaddr = 8'h0, araddr = 8'h0, pclr;
	logic [15:0] fw, fd;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	int miscompares = 0, tests_run = 0;
	always #10 aclk = ~aclk;
	prs_core #(.MEM_BYTES(32768)) u_prs_core (.aclk, .aresetn, .brownout_control_mode(mode),
		.stack_overflow_reset_enable(ovr), .core_op(op), .core_target(tgt), .core_pcl_wdata(pclw), .reset_event(ev),
		.global_irq_enable_high(gh), .global_irq_enable_low(gl), .fetch_word(fw), .pc_out(pc), .fetch_data(fd),
		.pcl_rdata(pclr), .stack_reset_req(srq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	prs_fetch_mem u_prs_fetch_mem (.pc_out(pc), .fetch_word(fw));
	// ==========
	// helpers
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic act(input logic [3:0] o, input logic [3:0] e, input logic [20:0] t);
		@(posedge aclk);
		op <= o;
		ev <= e;
		tgt <= t;
		@(posedge aclk);
		op <= 4'h0;
		ev <= 4'h0;
		#1;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, da, dw;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		da = 1'b0;
		dw = 1'b0;
		while (!(da && dw))
		begin
			@(negedge aclk);
			ta = awready;
			tw = wready;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			da = da | ta;
			dw = dw | tw;
		end
		while (!bvalid)
			@(negedge aclk);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		logic t;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		t = 1'b0;
		while (!t)
		begin
			@(negedge aclk);
			t = arready;
			@(posedge aclk);
		end
		arvalid <= 1'b0;
		while (!rvalid)
			@(negedge aclk);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		axw(a, v);
		chk(r, `PRS_RESP_OKAY);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		axr(a);
		chk(r, `PRS_RESP_OKAY);
		chk(d, e);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_reset();
		rdc(`PRS_OFF_CAUSE, 32'h5c);
		rdc(`PRS_OFF_RETURN_STACK_POINTER, 32'h0);
		chk(pc, 32'h0);
	endtask
	task automatic t_stack();
		act(prs_pkg::PRS_OP_JUMP, 4'h0, 21'h100);
		act(prs_pkg::PRS_OP_CALL, 4'h0, 21'h2000);
		act(prs_pkg::PRS_OP_CALL, 4'h0, 21'h3000);
		rdc(`PRS_OFF_RETURN_STACK_POINTER, 32'h2);
		rdc(`PRS_OFF_TOS, 32'h2002);
		act(prs_pkg::PRS_OP_RET, 4'h0, 21'h0);
		chk(pc, 32'h2002);
		act(prs_pkg::PRS_OP_RET, 4'h0, 21'h0);
		chk(pc, 32'h102);
		act(prs_pkg::PRS_OP_RET, 4'h0, 21'h0);
		chk(pc, 32'h0);
		rdc(`PRS_OFF_RETURN_STACK_POINTER, 32'h40);
		act(prs_pkg::PRS_OP_IRQ_LOW, 4'h0, 21'h0);
		rdc(`PRS_OFF_RETURN_STACK_POINTER, 32'h41);
		wr(`PRS_OFF_RETURN_STACK_POINTER, 32'h1);
		wr(`PRS_OFF_TOS, 32'h4444);
		act(prs_pkg::PRS_OP_RET, 4'h0, 21'h0);
		chk(pc, 32'h4444);
		rdc(`PRS_OFF_RETURN_STACK_POINTER, 32'h0);
		act(prs_pkg::PRS_OP_PUSH, 4'h0, 21'h0);
		rdc(`PRS_OFF_TOS, 32'h4444);
		rdc(`PRS_OFF_RETURN_STACK_POINTER, 32'h1);
		act(prs_pkg::PRS_OP_POP, 4'h0, 21'h0);
		rdc(`PRS_OFF_RETURN_STACK_POINTER, 32'h0);
		chk(pc, 32'h4448);
	endtask
	task automatic t_full();
		for (int i = 0; i < 31; i++)
			act(prs_pkg::PRS_OP_CALL, 4'h0, 21'h1000);
		rdc(`PRS_OFF_RETURN_STACK_POINTER, 32'h9f);
		act(prs_pkg::PRS_OP_JUMP, 4'h0, 21'h600);
		act(prs_pkg::PRS_OP_CALL, 4'h0, 21'h1000);
		rdc(`PRS_OFF_RETURN_STACK_POINTER, 32'h9f);
		rdc(`PRS_OFF_TOS, 32'h1002);
		wr(`PRS_OFF_RETURN_STACK_POINTER, 32'h1e);
		@(posedge aclk);
		ovr <= 1'b1;
		act(prs_pkg::PRS_OP_CALL, 4'h0, 21'h700);
		chk({srq, pc}, {1'b1, 21'h0});
		rdc(`PRS_OFF_RETURN_STACK_POINTER, 32'h80);
		wr(`PRS_OFF_RETURN_STACK_POINTER, 32'h0);
		act(prs_pkg::PRS_OP_RET, 4'h0, 21'h0);
		chk({srq, pc}, {1'b1, 21'h0});
		rdc(`PRS_OFF_RETURN_STACK_POINTER, 32'h40);
		@(posedge aclk);
		ovr <= 1'b0;
		act(prs_pkg::PRS_OP_JUMP, 4'h0, 21'h800);
		act(prs_pkg::PRS_OP_RET, 4'h0, 21'h0);
		chk({srq, pc}, {1'b0, 21'h0});
	endtask
	task automatic t_events();
		logic [3:0] evs[10] = '{4'h2, 4'h7, 4'h5, 4'h8, 4'h3, 4'h9, 4'h9, 4'h9, 4'h4, 4'h6};
		logic [1:0] gs[10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
		logic [7:0] cs[10] = '{8'h4c, 8'h44, 8'h48, 8'h40, 8'h5c, 8'h58, 8'h58, 8'h58, 8'h58, 8'h58};
		logic [20:0] ps[10] = '{21'h0, 21'h0, 21'h0, 21'h402, 21'h0, 21'h402, 21'h18, 21'h8, 21'h0, 21'h0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge aclk);
			{gh, gl} <= gs[i];
			act(prs_pkg::PRS_OP_JUMP, 4'h0, 21'h400);
			act(4'h0, evs[i], 21'h0);
			chk(pc, ps[i]);
			rdc(`PRS_OFF_CAUSE, cs[i]);
		end
		act(4'h0, prs_pkg::PRS_EV_POR, 21'h0);
		rdc(`PRS_OFF_CAUSE, 32'h5c);
		@(posedge aclk);
		mode <= 2'h0;
		act(4'h0, prs_pkg::PRS_EV_POR, 21'h0);
		rdc(`PRS_OFF_CAUSE, 32'h1c);
	endtask
	task automatic t_pcl();
		wr(`PRS_OFF_LATH, 32'h12);
		wr(`PRS_OFF_LATU, 32'h03);
		@(posedge aclk);
		pclw <= 8'h44;
		act(prs_pkg::PRS_OP_PCL_WR, 4'h0, 21'h0);
		chk(pc, 32'h31244);
		act(prs_pkg::PRS_OP_JUMP, 4'h0, 21'hbcd0);
		act(prs_pkg::PRS_OP_PCL_RD, 4'h0, 21'h0);
		act(prs_pkg::PRS_OP_CALL, 4'h0, 21'h500);
		rdc(`PRS_OFF_LATH, 32'hbc);
		rdc(`PRS_OFF_LATU, 32'h0);
		rdc(`PRS_OFF_PCL, 32'h0);
		chk({fd, pclr}, {16'h0280 ^ 16'h5a5a, 8'h0});
		act(prs_pkg::PRS_OP_SEQ, 4'h0, 21'h0);
		chk(pc, 32'h502);
		act(prs_pkg::PRS_OP_JUMP, 4'h0, 21'h1ffffe);
		rdc(`PRS_OFF_PCRD, 32'h1ffffe);
		chk(fd, 32'h0);
		axr(8'h1c);
		chk({r, d}, {`PRS_RESP_SLVERR, 32'h0});
		axw(8'h1c, 32'h5);
		chk(r, `PRS_RESP_SLVERR);
	endtask
	// ==========
	// sequence
	initial
	begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_stack();
		t_full();
		t_pcl();
		t_events();
		give_verdict();
	end
	initial
	begin
		#400000;
		miscompares++;
		give_verdict();
	end
endmodule
